// ==== rtl/dtr_temp_regs.sv ====
`timescale 1ns/1ps

//Contract
//RULE1: Temperature readable as two byte registers, low at 0x60, high at 0x61.
//RULE2: Eleven-bit value: high register bits 2..0 on top, low register all eight below.
//RULE3: Unsigned kelvin count, one step equals a quarter kelvin.
//RULE4: High register bits 7..3 are reserved and cleared on power-on reset.
//RULE5: Host masks the five upper high-register bits before using the value.
//RULE6: Both registers read-only; writes change nothing, reads have no side effects.
module dtr_temp_regs #(
    parameter int TEMP_WIDTH = dtr_pkg::TEMP_WIDTH
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  sample_valid,
    input  wire logic [TEMP_WIDTH-1:0] sample_temp,
    input  wire dtr_pkg::dtr_req_s     req,
    output      dtr_pkg::dtr_rsp_s     rsp,
    output      logic [TEMP_WIDTH-1:0] temp_value
);

    // Bit layout of the two byte registers
    localparam int BYTE_WIDTH = dtr_pkg::DATA_WIDTH;
    localparam int ADDR_WIDTH = dtr_pkg::ADDR_WIDTH;
    localparam int LOW_WIDTH  = dtr_pkg::DATA_WIDTH;
    localparam int HIGH_WIDTH = dtr_pkg::HIGH_FIELD_MSB + 1;
    localparam int HIGH_LSB   = LOW_WIDTH;
    localparam int RSVD_WIDTH = dtr_pkg::RSVD_WIDTH;
    localparam int RSVD_LSB   = HIGH_WIDTH;

    // Register table order
    localparam int REG_LOW    = 0;
    localparam int REG_HIGH   = 1;
    localparam int REG_COUNT  = REG_HIGH + 1;

    // Refuse widths, reset values and maps that the byte split cannot serve
    if (TEMP_WIDTH != LOW_WIDTH + HIGH_WIDTH) begin : g_bad_temp_width
        $error("dtr_temp_regs: TEMP_WIDTH must equal the low byte plus the high field");
    end

    if (HIGH_WIDTH + RSVD_WIDTH != BYTE_WIDTH) begin : g_bad_high_layout
        $error("dtr_temp_regs: high field and reserved field must fill one byte");
    end

    if (HIGH_LSB + HIGH_WIDTH != TEMP_WIDTH) begin : g_bad_high_lsb
        $error("dtr_temp_regs: high field must hold the top bits of the count");
    end

    if (TEMP_WIDTH <= BYTE_WIDTH) begin : g_bad_narrow_temp
        $error("dtr_temp_regs: the count must be wider than one byte");
    end

    if (dtr_pkg::HIGH_FIELD_MSB >= BYTE_WIDTH) begin : g_bad_high_msb
        $error("dtr_temp_regs: high field must fit inside the high register");
    end

    if ($bits(dtr_pkg::TEMP_RESET) != TEMP_WIDTH) begin : g_bad_temp_reset_width
        $error("dtr_temp_regs: temperature reset value must match TEMP_WIDTH");
    end

    if (dtr_pkg::TEMP_RESET != '0) begin : g_bad_temp_reset
        $error("dtr_temp_regs: temperature must read zero after reset");
    end

    if ($bits(dtr_pkg::RSVD_RESET) != RSVD_WIDTH) begin : g_bad_rsvd_reset_width
        $error("dtr_temp_regs: reserved reset value must match the reserved field");
    end

    if (dtr_pkg::RSVD_RESET != '0) begin : g_bad_rsvd_reset
        $error("dtr_temp_regs: reserved bits must clear to zero on reset");
    end

    if (dtr_pkg::ADDR_TEMP_LOW == dtr_pkg::ADDR_TEMP_HIGH) begin : g_bad_addr_map
        $error("dtr_temp_regs: the two register addresses must differ");
    end

    if ($bits(dtr_pkg::ADDR_TEMP_LOW) != ADDR_WIDTH) begin : g_bad_low_addr_width
        $error("dtr_temp_regs: low register address must match the address width");
    end

    if ($bits(dtr_pkg::ADDR_TEMP_HIGH) != ADDR_WIDTH) begin : g_bad_high_addr_width
        $error("dtr_temp_regs: high register address must match the address width");
    end

    if ($bits(dtr_pkg::READ_UNMAPPED) != BYTE_WIDTH) begin : g_bad_fill_width
        $error("dtr_temp_regs: idle read value must be one byte wide");
    end

    if (dtr_pkg::READ_UNMAPPED != '0) begin : g_bad_fill_value
        $error("dtr_temp_regs: idle and unmapped reads must show zero");
    end

    if (dtr_pkg::MILLI_K_PER_LSB <= 0) begin : g_bad_scale
        $error("dtr_temp_regs: the count scale must be positive");
    end

    // Stored conversion and the reserved field of the high register
    logic [TEMP_WIDTH-1:0] temp;
    logic [RSVD_WIDTH-1:0] rsvd;

    // Register views as the host reads them
    logic [BYTE_WIDTH-1:0] low_byte;
    logic [BYTE_WIDTH-1:0] high_byte;
    logic [BYTE_WIDTH-1:0] reg_view [REG_COUNT];
    logic [ADDR_WIDTH-1:0] reg_addr [REG_COUNT];

    // Address decode of the current request
    // Select qualified by the read strobe
    logic [REG_COUNT-1:0]  reg_sel;
    logic [REG_COUNT-1:0]  read_sel;
    logic                  sel_hit;

    // Read path ahead of the response flops
    logic                  next_valid;
    logic                  next_hit;
    logic [BYTE_WIDTH-1:0] next_rdata;

    // Response flops
    logic                  rsp_valid;
    logic                  rsp_hit;
    logic [BYTE_WIDTH-1:0] rsp_rdata;

    // Capture a new conversion; host writes never reach this register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            temp <= dtr_pkg::TEMP_RESET;
        end else if (sample_valid) begin
            temp <= sample_temp; // RULE3 RULE6
        end
    end

    // Reserved field holds its reset value
    // Nothing on the host side can set these bits
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rsvd <= dtr_pkg::RSVD_RESET; // RULE4
        end else begin
            rsvd <= rsvd;
        end
    end

    // Low register carries the lower bits of the count
    assign low_byte = temp[LOW_WIDTH-1:0]; // RULE2

    // High register: temperature field below, reserved field above
    // Reserved bits come from their own flops so nothing else can leak into them
    for (genvar bit_idx = 0; bit_idx < BYTE_WIDTH; bit_idx++) begin : g_high_bit
        if (bit_idx < HIGH_WIDTH) begin : g_temp_field
            assign high_byte[bit_idx] = temp[HIGH_LSB+bit_idx]; // RULE2
        end else begin : g_rsvd_field
            assign high_byte[bit_idx] = rsvd[bit_idx-RSVD_LSB]; // RULE4
        end
    end

    // Register table in address order; the read mux walks it
    assign reg_view[REG_LOW]  = low_byte;
    assign reg_view[REG_HIGH] = high_byte;
    assign reg_addr[REG_LOW]  = dtr_pkg::ADDR_TEMP_LOW;  // RULE1
    assign reg_addr[REG_HIGH] = dtr_pkg::ADDR_TEMP_HIGH; // RULE1

    // One comparator per register; writes are decoded nowhere, so they change nothing
    for (genvar reg_idx = 0; reg_idx < REG_COUNT; reg_idx++) begin : g_decode
        assign reg_sel[reg_idx]  = (req.addr == reg_addr[reg_idx]); // RULE1 RULE6
        assign read_sel[reg_idx] = req.rd & reg_sel[reg_idx];
    end

    assign sel_hit = |reg_sel;

    // Only a read strobe produces data; idle and unmapped cycles show zero
    always_comb begin
        next_valid = req.rd; // RULE6
        next_hit   = req.rd & sel_hit;
        next_rdata = dtr_pkg::READ_UNMAPPED;
        for (int idx = 0; idx < REG_COUNT; idx++) begin
            if (read_sel[idx]) begin
                next_rdata = reg_view[idx]; // RULE1 RULE2 RULE4
            end
        end
    end

    // Response valid one cycle after the read strobe; a read changes no state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= next_valid; // RULE6
        end
    end

    // Hit flag stands only with a valid response
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rsp_hit <= 1'b0;
        end else if (next_valid) begin
            rsp_hit <= next_hit; // RULE1
        end else begin
            rsp_hit <= 1'b0;
        end
    end

    // Read data stands for one cycle, then returns to the idle value
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rsp_rdata <= dtr_pkg::READ_UNMAPPED;
        end else if (next_valid) begin
            rsp_rdata <= next_rdata; // RULE1 RULE2
        end else begin
            rsp_rdata <= dtr_pkg::READ_UNMAPPED;
        end
    end

    assign rsp = '{valid: rsp_valid, hit: rsp_hit, rdata: rsp_rdata};

    // Registered copy of the stored count for the readout consumer
    // It trails the stored value by one cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            temp_value <= dtr_pkg::TEMP_RESET;
        end else begin
            temp_value <= temp; // RULE2
        end
    end

endmodule : dtr_temp_regs

// ==== rtl/dtr_pkg.sv ====
package dtr_pkg;

    localparam int           TEMP_WIDTH      = 11;
    localparam int           ADDR_WIDTH      = 8;
    localparam int           DATA_WIDTH      = 8;
    localparam int           HIGH_FIELD_MSB  = 2;
    localparam int           RSVD_WIDTH      = 5;
    localparam logic [7:0]   ADDR_TEMP_LOW   = 8'h60;
    localparam logic [7:0]   ADDR_TEMP_HIGH  = 8'h61;
    localparam logic [10:0]  TEMP_RESET      = 11'h000;
    localparam logic [4:0]   RSVD_RESET      = 5'h00;
    localparam logic [7:0]   READ_UNMAPPED   = 8'h00;
    // Quarter kelvin per count
    localparam int           MILLI_K_PER_LSB = 250;

    typedef struct packed {
        logic                  rd;
        logic                  wr;
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wdata;
    } dtr_req_s;

    typedef struct packed {
        logic                  valid;
        logic                  hit;
        logic [DATA_WIDTH-1:0] rdata;
    } dtr_rsp_s;

endpackage : dtr_pkg

// ==== dv/dtr_chk.sv ====
`timescale 1ns/1ps

module dtr_chk (
    input logic                           clock,
    input logic                           rst,
    input logic                           sample_valid,
    input logic [dtr_pkg::TEMP_WIDTH-1:0] sample_temp,
    input dtr_pkg::dtr_req_s              req,
    input dtr_pkg::dtr_rsp_s              rsp,
    input logic [dtr_pkg::TEMP_WIDTH-1:0] temp_value
);

    logic [dtr_pkg::TEMP_WIDTH-1:0] model_temp;

    // Reference count built from the conversion inputs only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            model_temp <= dtr_pkg::TEMP_RESET;
        end else if (sample_valid) begin
            model_temp <= sample_temp;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_lo_read: assert property (req.rd && req.addr == dtr_pkg::ADDR_TEMP_LOW |=> rsp.valid && rsp.hit && rsp.rdata == $past(model_temp[7:0])) else $error("low register read mismatch");
    a_hi_read: assert property (req.rd && req.addr == dtr_pkg::ADDR_TEMP_HIGH |=> rsp.valid && rsp.hit && rsp.rdata == {5'h00, $past(model_temp[10:8])}) else $error("high register read mismatch");
    a_no_hit: assert property (req.rd && req.addr != dtr_pkg::ADDR_TEMP_LOW && req.addr != dtr_pkg::ADDR_TEMP_HIGH |=> rsp.valid && !rsp.hit && rsp.rdata == 8'h00) else $error("unmapped read answered");
    a_temp_load: assert property (sample_valid |-> ##2 temp_value == $past(sample_temp, 2)) else $error("conversion not stored");
    a_temp_hold: assert property (!sample_valid |-> ##2 $stable(temp_value)) else $error("count changed without conversion");
    a_rsp_idle: assert property (!req.rd |=> !rsp.valid && !rsp.hit && rsp.rdata == 8'h00) else $error("response without read");

endmodule : dtr_chk

bind dtr_temp_regs dtr_chk chk (
    .clock       (clock),
    .rst         (rst),
    .sample_valid(sample_valid),
    .sample_temp (sample_temp),
    .req         (req),
    .rsp         (rsp),
    .temp_value  (temp_value)
);

// ==== dv/dtr_host.sv ====
`timescale 1ns/1ps

module dtr_host (
    input  logic              clock,
    input  dtr_pkg::dtr_rsp_s rsp,
    output dtr_pkg::dtr_req_s req
);

    initial begin
        req = '0;
    end

    // One access: request from a falling edge, answer taken one cycle later
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] wd, output dtr_pkg::dtr_rsp_s r);
        @(negedge clock);
        req = '{rd: !w, wr: w, addr: a, wdata: wd};
        @(negedge clock);
        r   = rsp;
        req = '0;
    endtask : acc

    task automatic get(output logic [10:0] t, output dtr_pkg::dtr_rsp_s lo, output dtr_pkg::dtr_rsp_s hi);
        acc(1'b0, dtr_pkg::ADDR_TEMP_LOW, 8'h00, lo);
        acc(1'b0, dtr_pkg::ADDR_TEMP_HIGH, 8'h00, hi);
        t = {hi.rdata[2:0], lo.rdata};
    endtask : get

endmodule : dtr_host

// ==== dv/tb.sv ====
`timescale 1ns/1ps

module tb;

    logic                           clock;
    logic                           rst;
    logic                           sample_valid;
    logic [dtr_pkg::TEMP_WIDTH-1:0] sample_temp;
    logic [dtr_pkg::TEMP_WIDTH-1:0] temp_value;
    dtr_pkg::dtr_req_s              req;
    dtr_pkg::dtr_rsp_s              rsp;
    int                             error_cnt = 0;
    int                             n_tests   = 0;

    dtr_temp_regs dut (
        .clock       (clock),
        .rst         (rst),
        .sample_valid(sample_valid),
        .sample_temp (sample_temp),
        .req         (req),
        .rsp         (rsp),
        .temp_value  (temp_value)
    );

    dtr_host host (
        .clock(clock),
        .rsp  (rsp),
        .req  (req)
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Read both registers and judge them against the expected count
    task automatic read_and_judge(input logic [10:0] exp_temp);
        logic [10:0]       t;
        dtr_pkg::dtr_rsp_s lo;
        dtr_pkg::dtr_rsp_s hi;
        host.get(t, lo, hi);
        check("low valid", 32'h0000_0001, 32'(lo.valid));
        check("low hit", 32'h0000_0001, 32'(lo.hit));
        check("high valid", 32'h0000_0001, 32'(hi.valid));
        check("high hit", 32'h0000_0001, 32'(hi.hit));
        check("low byte", 32'(exp_temp[7:0]), 32'(lo.rdata));
        check("high reserved", 32'h0000_0000, 32'(hi.rdata[7:3]));
        check("temperature", 32'(exp_temp), 32'(t));
        check("temp value", 32'(exp_temp), 32'(temp_value));
    endtask : read_and_judge

    task automatic load_sample(input logic [10:0] v);
        @(negedge clock);
        sample_valid = 1'b1;
        sample_temp  = v;
        @(negedge clock);
        sample_valid = 1'b0;
    endtask : load_sample

    task automatic t_reset_values;
        read_and_judge(dtr_pkg::TEMP_RESET);
    endtask : t_reset_values

    // Host writes to both addresses must leave the count alone
    task automatic t_load(input logic [10:0] v);
        dtr_pkg::dtr_rsp_s r;
        load_sample(v);
        host.acc(1'b1, dtr_pkg::ADDR_TEMP_LOW, ~v[7:0], r);
        check("write low response", 32'h0000_0000, 32'(r.valid));
        host.acc(1'b1, dtr_pkg::ADDR_TEMP_HIGH, 8'hff, r);
        check("write high response", 32'h0000_0000, 32'(r.valid));
        read_and_judge(v);
    endtask : t_load

    task automatic t_unmapped;
        dtr_pkg::dtr_rsp_s r;
        host.acc(1'b0, dtr_pkg::ADDR_TEMP_HIGH + 8'h01, 8'h00, r);
        check("unmapped valid", 32'h0000_0001, 32'(r.valid));
        check("unmapped hit", 32'h0000_0000, 32'(r.hit));
        check("unmapped data", 32'h0000_0000, 32'(r.rdata));
    endtask : t_unmapped

    // 300 kelvin is 1200 quarter-kelvin steps
    task automatic t_scale;
        logic [10:0]       t;
        dtr_pkg::dtr_rsp_s lo;
        dtr_pkg::dtr_rsp_s hi;
        load_sample(11'h4b0);
        host.get(t, lo, hi);
        check("millikelvin", 32'h0004_93e0, 32'(32'(t) * dtr_pkg::MILLI_K_PER_LSB));
    endtask : t_scale

    task automatic t_mid_reset;
        load_sample(11'h5a5);
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        read_and_judge(dtr_pkg::TEMP_RESET);
    endtask : t_mid_reset

    task automatic finish_test;
        $display("Checks %0d, errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        rst          = 1'b1;
        sample_valid = 1'b0;
        sample_temp  = '0;
        repeat (5) @(negedge clock);
        rst = 1'b0;
        t_reset_values;
        t_load(11'h7ff);
        t_load(11'h2a5);
        t_unmapped;
        t_scale;
        t_mid_reset;
        finish_test;
    end

endmodule : tb
